// ---- tb/iol_executor_assertions.sv ----
/* Port checker for the executor; assumes one clock and the two-flop input synchroniser. */
module iol_chk
  import iol_pkg::*;
#(parameter int unsigned IN_AW = 2, OUT_AW = 2) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [2:0] instr_op,
  input wire logic [IN_AW-1:0] instr_in_addr,
  input wire logic [OUT_AW-1:0] instr_out_addr,
  input wire logic [(1<<IN_AW)-1:0] in_pins,
  input wire logic [(1<<IN_AW)-1:0] in_image,
  input wire logic [(1<<OUT_AW)-1:0] out_pins,
  input wire logic [(1<<OUT_AW)-1:0] out_image,
  input wire logic rung_acc,
  input wire logic instr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [(1<<IN_AW)-1:0] p1, p2;
  wire s = p2[instr_in_addr];
  wire [3:0] c = instr_valid ? {1'b1, instr_op} : 4'h0;
  always_ff @(posedge ref_clk) {p2, p1} <= {p1, in_pins};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_begin_load: assert property (c == 4'h8 |=> rung_acc == $past(s)) else $error("begin");
  a_begin_inv: assert property (c == 4'h9 |=> rung_acc == !$past(s)) else $error("begin_n");
  a_par_or: assert property (c == 4'ha |=> rung_acc == ($past(rung_acc) | $past(s))) else $error("or");
  a_par_inv: assert property (c == 4'hb |=> rung_acc == ($past(rung_acc) | !$past(s))) else $error("orn");
  a_ser_and: assert property (c == 4'hc |=> rung_acc == ($past(rung_acc) & $past(s))) else $error("and");
  a_ser_inv: assert property (c == 4'hd |=> rung_acc == ($past(rung_acc) & !$past(s))) else $error("andn");
  a_coil_pin: assert property (c == 4'he |=> out_pins[$past(instr_out_addr)] == $past(rung_acc)) else $error("coil");
  a_coil_image: assert property (c == 4'he |=> out_image[$past(instr_out_addr)] == $past(rung_acc)) else $error("img");
  a_ored_set: assert property (c == 4'hf && rung_acc |=> out_pins[$past(instr_out_addr)]) else $error("ored");
  a_done_pulse: assert property (instr_valid |=> instr_done) else $error("done");
  a_ored_hold: assert property (c == 4'hf && !rung_acc |=> out_pins == $past(out_pins))
    else $error("ored hold");
  a_idle_keep: assert property (!instr_valid |=> rung_acc == $past(rung_acc))
    else $error("idle");
endmodule
bind iol_executor iol_chk #(.IN_AW(IN_AW), .OUT_AW(OUT_AW)) chk_u (.*);

// ---- tb/iol_executor_test.sv ----
/* Executor bench; assumes the io model feeds the live points and the checker is bound. */
module iol_executor_test
  import iol_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst_n = 0, v = 0, ea = 0, p, acc, done;
  logic [2:0] op = 0;
  logic [1:0] ia = 0, oa = 0;
  logic [3:0] want = 0, eo = 0, pins, outp, immediate_coil_drive;
  int miscompares = 0, samples_checked = 0;
  initial forever #25 ref_clk = ~ref_clk;
  iol_io_model io_u (.ref_clk(ref_clk), .want(want), .in_pins(pins));
  iol_executor #(.IN_AW(2), .OUT_AW(2)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .instr_valid(v), .instr_op(op), .instr_in_addr(ia), .instr_out_addr(oa), .in_pins(pins),
    .in_image(4'hf), .out_pins(outp), .out_image(immediate_coil_drive), .rung_acc(acc), .instr_done(done));
  task chk(input string nm, input logic [3:0] s, input logic [3:0] e);
    samples_checked++;
    miscompares += int'(s !== e);
    if (s !== e) $display("Error %s exp %h seen %h", nm, e, s);
  endtask
  task run(input logic [2:0] o, input logic [1:0] i, k, input logic [3:0] w);
    want = w;
    // Points need the model flop plus two sync flops
    repeat (4) @(posedge ref_clk);
    p = w[i] ^ o[0];
    case (o[2:1])
      2'h0: ea = p;
      2'h1: ea = ea | p;
      2'h2: ea = ea & p;
      default: eo[k] = o[0] ? (eo[k] | ea) : ea;
    endcase
    #1 {v, op, ia, oa} = {1'b1, o, i, k};
    @(posedge ref_clk);
    #1 v = 0;
    chk("done", {3'h0, done}, 4'h1);
    chk("acc", {3'h0, acc}, {3'h0, ea});
    chk("out", outp, eo);
    chk("img", immediate_coil_drive, eo);
    @(posedge ref_clk);
    #1 chk("done_low", {3'h0, done}, 4'h0);
  endtask
  // Mid-run reset clears coils and accumulator, then a contact still works
  task s_reset;
    rst_n = 0;
    @(posedge ref_clk);
    #1 chk("rst_out", outp, 4'h0);
    chk("rst_acc", {3'h0, acc}, 4'h0);
    rst_n = 1;
    {ea, eo} = 5'h0;
    run(3'h3, 2'h0, 2'h0, 4'h0);
  endtask
  task s_contacts;
    for (int n = 0; n < 24; n++) run(3'(n % 6), 2'(n % 4), 2'h0, 4'(n * 5));
  endtask
  // Coil on point 1 toggles twice, ORed coil on point 2 stays set
  task s_coils;
    for (int n = 0; n < 8; n++) run(n[0] ? {2'h3, n[2]} : 3'h0, 2'h0, {n[2], !n[2]}, {3'h0, !n[1]});
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1;
    s_contacts;
    s_coils;
    s_reset;
    print_verdict;
  end
endmodule

// ---- tb/iol_io_model.sv ----
/* Discrete input module model; assumes the bench names the pattern it wants on the points. */
module iol_io_model (
  input wire logic ref_clk,
  input wire logic [3:0] want,
  output logic [3:0] in_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge ref_clk) in_pins <= want;
endmodule

// ---- verilog/iol_executor.sv ----
/*
 * Immediate I/O ladder instruction executor: six live-input contacts
 * and two immediate coils acting on a one-bit rung accumulator.
 * Assumes the input module points are asynchronous pins and that the
 * sequencer issues at most one instruction per cycle with a one-cycle
 * strobe; scan-start clearing of ORed coils is done by the sequencer.
 */
//
// Overview of operation
// - A rung-begin contact loads the accumulator with the live input point.
// - An inverted rung-begin contact loads the accumulator with the inverse live point.
// - A parallel contact ORs the live input point into the accumulator.
// - An inverted parallel contact ORs the inverse live point into the accumulator.
// - A series contact ANDs the live input point into the accumulator.
// - An inverted series contact ANDs the inverse live point into the accumulator.
// - No contact instruction ever writes the input image.
// - The immediate coil drives the rung result to the output point and output image.
// - Every coil execution updates the output point, so it may toggle within a scan.
// - The ORed coil only turns its output on, so rungs sharing it are ORed.
module iol_executor
  import iol_pkg::*;
#(
  parameter int unsigned IN_AW  = IOL_IN_AW_DEF,
  parameter int unsigned OUT_AW = IOL_OUT_AW_DEF
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   instr_valid,
  input  wire logic [IOL_OP_W-1:0]    instr_op,
  input  wire logic [IN_AW-1:0]       instr_in_addr,
  input  wire logic [OUT_AW-1:0]      instr_out_addr,
  input  wire logic [(1<<IN_AW)-1:0]  in_pins,
  input  wire logic [(1<<IN_AW)-1:0]  in_image,
  output logic [(1<<OUT_AW)-1:0]      out_pins,
  output logic [(1<<OUT_AW)-1:0]      out_image,
  output logic                        rung_acc,
  output logic                        instr_done
);

  localparam int unsigned NIN  = 1 << IN_AW;
  localparam int unsigned NOUT = 1 << OUT_AW;

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Point vectors grow as two to the address width, so the width is capped
  if (IN_AW < 1) begin : g_in_aw_low
    $error("iol_executor: IN_AW must be at least 1");
  end

  if (IN_AW > 16) begin : g_in_aw_high
    $error("iol_executor: IN_AW must be at most 16");
  end

  if (OUT_AW < 1) begin : g_out_aw_low
    $error("iol_executor: OUT_AW must be at least 1");
  end

  if (OUT_AW > 16) begin : g_out_aw_high
    $error("iol_executor: OUT_AW must be at most 16");
  end

  // Decode below covers exactly eight opcodes
  if (IOL_OP_W != 3) begin : g_op_w
    $error("iol_executor: opcode field must be 3 bits");
  end

  typedef struct packed {
    logic [NIN-1:0]  sync1;
    logic [NIN-1:0]  sync2;
    logic            acc;
    logic [NOUT-1:0] pins;
    logic [NOUT-1:0] image;
    logic            done;
  } iol_state_t;

  iol_state_t st_q;
  iol_state_t st_d;

  ////////////////////////////////////////////////////////////////////////
  // Contact evaluation

  // Opcode classes
  function automatic logic iol_is_contact(input logic [IOL_OP_W-1:0] op);
    logic hit;
    hit = 1'b0;
    unique case (op)
      IOL_OP_RUNG_BEGIN,
      IOL_OP_RUNG_BEGIN_INV,
      IOL_OP_PARALLEL,
      IOL_OP_PARALLEL_INV,
      IOL_OP_SERIES,
      IOL_OP_SERIES_INV: begin
        hit = 1'b1;
      end
      IOL_OP_COIL_DRIVE,
      IOL_OP_ORED_COIL: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  function automatic logic iol_is_coil(input logic [IOL_OP_W-1:0] op);
    logic hit;
    hit = 1'b0;
    unique case (op)
      IOL_OP_COIL_DRIVE,
      IOL_OP_ORED_COIL: begin
        hit = 1'b1;
      end
      IOL_OP_RUNG_BEGIN,
      IOL_OP_RUNG_BEGIN_INV,
      IOL_OP_PARALLEL,
      IOL_OP_PARALLEL_INV,
      IOL_OP_SERIES,
      IOL_OP_SERIES_INV: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Contact state seen by the rung, plain or inverted
  function automatic logic iol_contact(input logic                live,
                                       input logic [IOL_OP_W-1:0] op);
    logic state;
    state = live;
    unique case (op)
      IOL_OP_RUNG_BEGIN,
      IOL_OP_PARALLEL,
      IOL_OP_SERIES: begin
        state = live;
      end
      IOL_OP_RUNG_BEGIN_INV,
      IOL_OP_PARALLEL_INV,
      IOL_OP_SERIES_INV: begin
        state = ~live;
      end
      IOL_OP_COIL_DRIVE,
      IOL_OP_ORED_COIL: begin
        state = live;
      end
    endcase
    return state;
  endfunction

  // New accumulator value after a contact
  function automatic logic iol_combine(input logic                acc,
                                       input logic                cbit,
                                       input logic [IOL_OP_W-1:0] op);
    logic res;
    res = acc;
    unique case (op)
      IOL_OP_RUNG_BEGIN: begin
        res = cbit;
      end
      IOL_OP_RUNG_BEGIN_INV: begin
        res = cbit;
      end
      IOL_OP_PARALLEL: begin
        res = acc | cbit;
      end
      IOL_OP_PARALLEL_INV: begin
        res = acc | cbit;
      end
      IOL_OP_SERIES: begin
        res = acc & cbit;
      end
      IOL_OP_SERIES_INV: begin
        res = acc & cbit;
      end
      IOL_OP_COIL_DRIVE,
      IOL_OP_ORED_COIL: begin
        res = acc;
      end
    endcase
    return res;
  endfunction

  // New value of an output point after a coil
  function automatic logic iol_coil_next(input logic                old,
                                         input logic                acc,
                                         input logic [IOL_OP_W-1:0] op);
    logic res;
    res = old;
    unique case (op)
      IOL_OP_COIL_DRIVE: begin
        res = acc;
      end
      IOL_OP_ORED_COIL: begin
        // Off rungs leave the point alone so any on rung wins
        res = old | acc;
      end
      IOL_OP_RUNG_BEGIN,
      IOL_OP_RUNG_BEGIN_INV,
      IOL_OP_PARALLEL,
      IOL_OP_PARALLEL_INV,
      IOL_OP_SERIES,
      IOL_OP_SERIES_INV: begin
        res = old;
      end
    endcase
    return res;
  endfunction

  logic live_bit;
  logic contact;
  logic is_contact;
  logic is_coil;
  logic coil_pin;
  logic coil_img;

  // Only the second synchroniser stage reaches logic
  assign live_bit   = st_q.sync2[instr_in_addr];
  assign contact    = iol_contact(live_bit, instr_op);
  assign is_contact = iol_is_contact(instr_op);
  assign is_coil    = iol_is_coil(instr_op);
  assign coil_pin   = iol_coil_next(st_q.pins[instr_out_addr], st_q.acc, instr_op);
  assign coil_img   = iol_coil_next(st_q.image[instr_out_addr], st_q.acc, instr_op);

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d       = st_q;
    st_d.sync1 = in_pins;
    st_d.sync2 = st_q.sync1;
    st_d.done  = instr_valid;
    // Image input is never touched here; it belongs to the scan logic
    if (instr_valid && is_contact) begin
      st_d.acc = iol_combine(st_q.acc, contact, instr_op);
    end
    if (instr_valid && is_coil) begin
      // Writes every time, even to a point already driven this scan
      st_d.pins[instr_out_addr]  = coil_pin;
      st_d.image[instr_out_addr] = coil_img;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.sync1 <= '0;
      st_q.sync2 <= '0;
      st_q.acc   <= IOL_ACC_RST;
      st_q.pins  <= {NOUT{IOL_PIN_RST}};
      st_q.image <= {NOUT{IOL_IMAGE_RST}};
      st_q.done  <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign out_pins   = st_q.pins;
  assign out_image  = st_q.image;
  assign rung_acc   = st_q.acc;
  assign instr_done = st_q.done;

endmodule

// ---- verilog/iol_pkg.sv ----
/*
 * Shared constants and types for the immediate I/O ladder executor.
 * Assumes a single 20 MHz clock domain and one instruction issued at a time.
 */
package iol_pkg;

  localparam int unsigned IOL_IN_AW_DEF  = 10;
  localparam int unsigned IOL_OUT_AW_DEF = 10;
  localparam int unsigned IOL_OP_W       = 3;

  // Opcode field encodings
  localparam logic [2:0] IOL_OP_RUNG_BEGIN     = 3'h0;
  localparam logic [2:0] IOL_OP_RUNG_BEGIN_INV = 3'h1;
  localparam logic [2:0] IOL_OP_PARALLEL       = 3'h2;
  localparam logic [2:0] IOL_OP_PARALLEL_INV   = 3'h3;
  localparam logic [2:0] IOL_OP_SERIES         = 3'h4;
  localparam logic [2:0] IOL_OP_SERIES_INV     = 3'h5;
  localparam logic [2:0] IOL_OP_COIL_DRIVE     = 3'h6;
  localparam logic [2:0] IOL_OP_ORED_COIL      = 3'h7;

  localparam logic       IOL_ACC_RST   = 1'b0;
  localparam logic       IOL_PIN_RST   = 1'b0;
  localparam logic       IOL_IMAGE_RST = 1'b0;

endpackage
